/* File: bench/flash_erase_seq_properties.sv */
// Concurrent checks on the erase sequencer's top-level ports.
module flash_erase_seq_properties #(
  parameter int PAUSE_CYC = 4       // Pause latency in cycles, as in the design.
) (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic        i_wren_pulse,
  input wire logic        i_prot_half,
  input wire logic        i_prot_whole,
  input wire logic        i_prot_any,
  input wire logic        o_write_in_progress,
  input wire logic        o_write_enable_latch,
  input wire logic        o_erase_paused_flag,
  input wire logic        o_asleep,
  input wire logic        o_erase_go,
  input wire logic [1:0]  o_erase_kind,
  input wire logic [23:0] o_erase_addr,
  input wire logic        o_erase_done
);
  // One cycle of slack, because busy comes from a registered state.
  localparam int PAUSE_MAX  = PAUSE_CYC + 1;
  localparam int RESUME_MAX = flash_seq_pkg::RESUME_CYC;  // 200 ns at 20 MHz.
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Erase start and end.
  chk_go_needs_latch:
  assert property (o_erase_go |-> o_write_enable_latch && o_write_in_progress)
    else $error("erase started without latch or busy");
  chk_go_unprotected:
  assert property (o_erase_go |-> !(o_erase_kind == 2'h1 && i_prot_half)
    && !(o_erase_kind == 2'h2 && i_prot_whole) && !(o_erase_kind == 2'h3 && i_prot_any))
    else $error("protected region erased");
  chk_go_block_base:
  assert property (o_erase_go |-> (o_erase_kind != 2'h1 || o_erase_addr[14:0] == 15'h0)
    && (o_erase_kind != 2'h2 || o_erase_addr[15:0] == 16'h0))
    else $error("erase address not a block base");
  chk_busy_held:
  assert property (o_erase_go |=> o_write_in_progress [*4])
    else $error("busy dropped right after start");
  chk_done_clears:
  assert property (o_erase_done && !i_wren_pulse |=> !o_write_enable_latch
    && !o_write_in_progress)
    else $error("flags not cleared after erase");
  // ==========================================================
  // Pause, resume and sleep.
  chk_pause_needs_busy:
  assert property ($rose(o_erase_paused_flag) |-> $past(o_write_in_progress))
    else $error("pause accepted while idle");
  chk_pause_drops_busy:
  assert property ($rose(o_erase_paused_flag) |-> ##[0:PAUSE_MAX] !o_write_in_progress)
    else $error("busy not dropped within pause latency");
  chk_resume_busy:
  assert property ($fell(o_erase_paused_flag) |-> !$past(o_write_in_progress)
    ##[0:RESUME_MAX] o_write_in_progress)
    else $error("resume did not restart in time");
  chk_paused_no_go:
  assert property (o_erase_paused_flag |-> !o_erase_go)
    else $error("erase started while paused");
  chk_asleep_no_go:
  assert property (o_asleep |-> !o_erase_go)
    else $error("erase started while asleep");
endmodule

bind flash_erase_seq flash_erase_seq_properties #(.PAUSE_CYC(PAUSE_CYC)) i_props (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wren_pulse(i_wren_pulse), .i_prot_half(i_prot_half),
  .i_prot_whole(i_prot_whole), .i_prot_any(i_prot_any),
  .o_write_in_progress(o_write_in_progress), .o_write_enable_latch(o_write_enable_latch),
  .o_erase_paused_flag(o_erase_paused_flag), .o_asleep(o_asleep), .o_erase_go(o_erase_go),
  .o_erase_kind(o_erase_kind), .o_erase_addr(o_erase_addr), .o_erase_done(o_erase_done));

/* File: bench/flash_erase_seq_tb.sv */
// Self-checking bench for the erase, pause, resume and sleep sequencer.
module flash_erase_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ER = 20;   // Shortened erase length, all kinds.
  localparam int PC = 4;    // Shortened pause latency.
  localparam int SC = 4;    // Shortened sleep entry.
  localparam int F_GO = 0, F_DONE = 1, F_BUSY = 2, F_PAUSE = 3, F_SLEEP = 4;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        quad = 1'b0;
  logic        wren = 1'b0;
  logic        p_half = 1'b0;
  logic        p_whole = 1'b0;
  logic        p_any = 1'b0;
  logic        lclk, cs_n, busy, latch, paused, asleep, go, done;
  logic [3:0]  dq;
  logic [3:0]  ldq, loe;    // Status bits and their output enables on the link.
  logic [1:0]  kind;
  logic [23:0] addr;
  int          mismatches = 0;
  int          cmp_count = 0;
  // ==========================================================
  // System clock, 50 ns period.
  always #25 i_mclk = ~i_mclk;
  flash_host_model i_flash_host_model (.i_quad(quad), .o_clk(lclk), .o_cs_n(cs_n), .o_dq(dq));
  flash_erase_seq #(.HALF_ERASE_CYC(ER), .WHOLE_ERASE_CYC(ER), .CHIP_ERASE_CYC(ER),
    .PAUSE_CYC(PC), .SLEEP_CYC(SC)) i_flash_erase_seq (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_link_clk(lclk), .i_link_cs_n(cs_n),
    .i_link_dq(dq), .i_quad_mode(quad), .i_wren_pulse(wren), .i_prot_half(p_half),
    .i_prot_whole(p_whole), .i_prot_any(p_any), .o_link_dq(ldq), .o_link_dq_oe(loe),
    .o_write_in_progress(busy), .o_write_enable_latch(latch), .o_erase_paused_flag(paused),
    .o_asleep(asleep), .o_erase_go(go), .o_erase_kind(kind), .o_erase_addr(addr),
    .o_erase_done(done));
  // ==========================================================
  // Shared helpers.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      F_GO:    return go;
      F_DONE:  return done;
      F_BUSY:  return busy;
      F_PAUSE: return paused;
      default: return asleep;
    endcase
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // Bounded wait; running out counts a mismatch and ends the run.
  task automatic wait_for(input int w, input logic v, input int lim);
    for (int n = 0; n < lim; n++) begin
      cyc(1);
      #1;
      if (pick(w) === v) return;
    end
    check(pick(w), v, "wait ran out");
    wrap_up();
  endtask
  // The flag must keep its value for n cycles.
  task automatic hold(input int w, input logic v, input int n);
    repeat (n) begin
      cyc(1);
      #1;
      check(pick(w), v, "flag moved");
    end
  endtask
  // Keeps chip select high long enough between frames, then sends.
  task automatic frame(input logic [31:0] v, input int n);
    cyc(5);
    i_flash_host_model.send(v, n);
  endtask
  task automatic wren_set();
    @(posedge i_mclk) wren <= 1'b1;
    @(posedge i_mclk) wren <= 1'b0;
  endtask
  // ==========================================================
  // Scenarios.
  task automatic s_erase(input logic [31:0] v, input int n, input logic [1:0] k,
                         input logic [23:0] base);
    wren_set();
    frame(v, n);
    wait_for(F_GO, 1'b1, 20);
    check(kind, k, "kind");
    if (k != 2'h3) check(addr, base, "block base");
    wait_for(F_DONE, 1'b1, ER + 10);
    cyc(1);
    #1;
    check({busy, latch}, 2'h0, "flags after erase");
  endtask
  task automatic s_refuse();
    frame({flash_seq_pkg::OP_HALF_BLOCK_ERASE, 24'h000000}, 32);
    hold(F_GO, 1'b0, 12);
    wren_set();
    frame({12'h000, flash_seq_pkg::OP_HALF_BLOCK_ERASE, 12'h000}, 20);
    hold(F_GO, 1'b0, 12);
    @(posedge i_mclk) {p_half, p_whole, p_any} <= 3'h7;
    frame({flash_seq_pkg::OP_HALF_BLOCK_ERASE, 24'h000000}, 32);
    hold(F_GO, 1'b0, 12);
    frame({flash_seq_pkg::OP_WHOLE_BLOCK_ERASE, 24'h000000}, 32);
    hold(F_GO, 1'b0, 12);
    frame({24'h000000, flash_seq_pkg::OP_CHIP_ERASE_A}, 8);
    hold(F_GO, 1'b0, 12);
    @(posedge i_mclk) {p_half, p_whole, p_any} <= 3'h0;
  endtask
  task automatic s_pause();
    wren_set();
    frame({flash_seq_pkg::OP_WHOLE_BLOCK_ERASE, 24'h050000}, 32);
    wait_for(F_GO, 1'b1, 20);
    frame({24'h000000, flash_seq_pkg::OP_PAUSE}, 8);
    wait_for(F_PAUSE, 1'b1, 20);
    wait_for(F_BUSY, 1'b0, PC + 2);
    wren_set();
    // Status stays readable on the link while paused and selected.
    fork
      frame({flash_seq_pkg::OP_WHOLE_BLOCK_ERASE, 24'h070000}, 32);
      begin
        cyc(12);
        #1;
        check({ldq, loe}, 8'haf, "status on link");
      end
    join
    hold(F_GO, 1'b0, 12);
    frame({24'h000000, flash_seq_pkg::OP_CONTINUE}, 8);
    wait_for(F_PAUSE, 1'b0, 20);
    wait_for(F_BUSY, 1'b1, 4);
    wait_for(F_DONE, 1'b1, ER + 10);
    frame({24'h000000, flash_seq_pkg::OP_CONTINUE}, 8);
    hold(F_BUSY, 1'b0, 10);
  endtask
  task automatic s_chip_pause();
    wren_set();
    frame({24'h000000, flash_seq_pkg::OP_CHIP_ERASE_B}, 8);
    wait_for(F_GO, 1'b1, 20);
    frame({24'h000000, flash_seq_pkg::OP_PAUSE}, 8);
    hold(F_PAUSE, 1'b0, 6);
    check(busy, 1'b1, "chip erase stopped");
    wait_for(F_DONE, 1'b1, ER + 10);
  endtask
  task automatic s_power_loss();
    wren_set();
    frame({flash_seq_pkg::OP_HALF_BLOCK_ERASE, 24'h018000}, 32);
    wait_for(F_GO, 1'b1, 20);
    frame({24'h000000, flash_seq_pkg::OP_PAUSE}, 8);
    wait_for(F_PAUSE, 1'b1, 20);
    @(posedge i_mclk) i_rst_n <= 1'b0;
    cyc(3);
    i_rst_n <= 1'b1;
    cyc(4);
    #1;
    check(paused, 1'b0, "pause kept over power loss");
    frame({24'h000000, flash_seq_pkg::OP_CONTINUE}, 8);
    hold(F_BUSY, 1'b0, 10);
  endtask
  task automatic s_sleep();
    frame({20'h00000, flash_seq_pkg::OP_SLEEP, 4'h0}, 12);
    hold(F_SLEEP, 1'b0, 10);
    frame({24'h000000, flash_seq_pkg::OP_SLEEP}, 8);
    wait_for(F_SLEEP, 1'b1, SC + 6);
    wren_set();
    // A long frame while asleep: no erase and no status driven back.
    fork
      frame({flash_seq_pkg::OP_HALF_BLOCK_ERASE, 24'h000000}, 32);
      begin
        cyc(12);
        #1;
        check(loe, 4'h0, "status driven while asleep");
      end
    join
    hold(F_GO, 1'b0, 12);
    check(asleep, 1'b1, "woke on wrong opcode");
    frame({24'h000000, flash_seq_pkg::OP_WAKE}, 8);
    wait_for(F_SLEEP, 1'b0, 12);
    cyc(flash_seq_pkg::WAKE_CYC);
    s_erase({flash_seq_pkg::OP_HALF_BLOCK_ERASE, 24'h3f9abc}, 32, 2'h1, 24'h3f8000);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    cyc(20);
    i_rst_n <= 1'b1;
    cyc(1);
    #1;
    check({asleep, paused, busy, latch}, 4'h0, "power-up state");
    s_refuse();
    s_erase({flash_seq_pkg::OP_HALF_BLOCK_ERASE, 24'h12b456}, 32, 2'h1, 24'h128000);
    @(posedge i_mclk) quad <= 1'b1;
    s_erase({flash_seq_pkg::OP_WHOLE_BLOCK_ERASE, 24'h12b456}, 32, 2'h2, 24'h120000);
    s_erase({24'h000000, flash_seq_pkg::OP_CHIP_ERASE_A}, 8, 2'h3, 24'h000000);
    @(posedge i_mclk) quad <= 1'b0;
    s_erase({24'h000000, flash_seq_pkg::OP_CHIP_ERASE_B}, 8, 2'h3, 24'h000000);
    s_pause();
    s_chip_pause();
    s_power_loss();
    s_sleep();
    wrap_up();
  end
endmodule

/* File: bench/flash_host_model.sv */
// Behavioural host controller that shifts instruction frames into the device.
module flash_host_model (
  input  wire logic       i_quad,   // High sends four bits per link clock.
  output logic            o_clk,    // Link clock, still outside frames.
  output logic            o_cs_n,   // Chip select, active low.
  output logic [3:0]      o_dq      // Data lines towards the device.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_clk = 1'b0;
    o_cs_n = 1'b1;
    o_dq = 4'h5;
  end
  // Sends the low n bits of v, MSB first; the caller picks n on a byte boundary
  // unless it means the frame to be cut short.
  task automatic send(input logic [31:0] v, input int n);
    o_cs_n = 1'b0;
    for (int b = n; b > 0; b -= (i_quad ? 4 : 1)) begin
      o_dq = i_quad ? v[b-1 -: 4] : {~o_dq[3:1], v[b-1]};
      #7.5 o_clk = 1'b1;
      #7.5 o_clk = 1'b0;
    end
    #7.5 o_cs_n = 1'b1;
    // Released lines must not look like the last bit sent.
    o_dq = ~o_dq;
  endtask
endmodule

/* File: hw/flash_erase_seq.sv */
// Serial flash instruction decoder for block/chip erase, pause, resume and sleep.
// Function
// - Opcode 52h plus address erases 32K block.
// - Opcode D8h plus address erases 64K block.
// - C7h or 60h erases the whole array.
// - Erases accepted only while write enable latch set.
// - Chip select off byte boundary discards command.
// - Busy bit high during self-timed erase, reads allowed.
// - Erase completion clears the write enable latch.
// - Protected targets are never erased.
// - Pause accepted only when busy and not paused.
// - Pause ignored during full array erase.
// - Pause sets flag now, drops busy within latency.
// - While paused, status writes, program, erase refused.
// - Resume clears flag, busy again within 200ns.
// - Resume ignored unless paused and idle, or lost.
// - Power loss clears the paused state.
// - Opcode B9h enters sleep after entry latency.
// - Asleep, only wake opcode is recognised.
// - Power-up always starts awake.
// - Opcode ABh alone wakes; host waits wake latency.
module flash_erase_seq #(
  parameter int unsigned HALF_ERASE_CYC  = flash_seq_pkg::HALF_BLOCK_ERASE_CYC,
  parameter int unsigned WHOLE_ERASE_CYC = flash_seq_pkg::WHOLE_BLOCK_ERASE_CYC,
  parameter int unsigned CHIP_ERASE_CYC  = flash_seq_pkg::FULL_ARRAY_ERASE_CYC,
  parameter int unsigned PAUSE_CYC       = flash_seq_pkg::PAUSE_LAT_CYC,
  parameter int unsigned SLEEP_CYC       = flash_seq_pkg::SLEEP_ENTRY_CYC
) (
  input  wire logic        i_mclk,           // System clock, 20 MHz.
  input  wire logic        i_rst_n,          // Power-on reset, active low.
  input  wire logic        i_link_clk,       // Serial clock from the host.
  input  wire logic        i_link_cs_n,      // Chip select, active low.
  input  wire logic [3:0]  i_link_dq,        // Data pins as seen from outside.
  input  wire logic        i_quad_mode,      // High selects four-wire instructions.
  input  wire logic        i_wren_pulse,     // One-cycle request to set the latch.
  input  wire logic        i_prot_half,      // Addressed 32K region is protected.
  input  wire logic        i_prot_whole,     // Addressed 64K region is protected.
  input  wire logic        i_prot_any,       // Some page of the array is protected.
  output logic [3:0]       o_link_dq,        // Status bits driven back.
  output logic [3:0]       o_link_dq_oe,     // Output enables, high while driving.
  output logic             o_write_in_progress,
  output logic             o_write_enable_latch,
  output logic             o_erase_paused_flag,
  output logic             o_asleep,
  output logic             o_erase_go,       // One-cycle pulse: erase begins.
  output logic [1:0]       o_erase_kind,     // Kind of erase started or running.
  output logic [23:0]      o_erase_addr,     // Block base address of the erase.
  output logic             o_erase_done      // One-cycle pulse: erase finished.
);
  // ==========================================================
  // Parameter checks.
  initial begin
    if (PAUSE_CYC < 1 || SLEEP_CYC < 1 || HALF_ERASE_CYC < 2 || WHOLE_ERASE_CYC < 2
        || CHIP_ERASE_CYC < 2) begin
      $error("flash_erase_seq: counts out of range");
    end
  end

  // ==========================================================
  // Reset release: asynchronous assert, two-flop release.
  logic rst_sync1_q;  // First reset flop.
  logic rst_n_q;      // Reset copy used by the system domain.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync1_q <= 1'b0;
      rst_n_q     <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_n_q     <= rst_sync1_q;
    end
  end

  // ==========================================================
  // Link domain: shift instruction and address bits while selected.
  // Chip select clears only the in-frame flag, so the first edge of a frame
  // restarts the count; count and word then stand until the next frame.
  logic [5:0]  bit_cnt_q;   // Bits received in the latest frame, saturating.
  logic [31:0] shift_q;     // Opcode then address, most recent in the low bits.
  logic        in_frame_q;  // At least one link edge seen since select fell.
  logic        frame_tog_q; // Toggles at the first edge of every frame.
  logic [5:0]  bit_step;    // Bits added per edge.
  logic [31:0] shift_d;     // Next shift value.
  always_comb begin
    bit_step = i_quad_mode ? 6'h04 : 6'h01;
    shift_d  = i_quad_mode ? {shift_q[27:0], i_link_dq} : {shift_q[30:0], i_link_dq[0]};
  end
  // In-frame flag: cleared at once while chip select is high.
  always_ff @(posedge i_link_clk or posedge i_link_cs_n) begin
    if (i_link_cs_n) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
    end
  end
  // Count and word need no reset: they are read only after a fresh frame.
  always_ff @(posedge i_link_clk) begin
    shift_q <= shift_d;
    if (!in_frame_q) begin
      bit_cnt_q <= bit_step;
    end else if (bit_cnt_q >= 6'h3b) begin
      bit_cnt_q <= 6'h3f;
    end else begin
      bit_cnt_q <= bit_cnt_q + bit_step;
    end
  end
  // Frame toggle: a select with no clocks at all would otherwise replay the
  // command of the frame before it.
  always_ff @(posedge i_link_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      frame_tog_q <= 1'b0;
    end else if (!in_frame_q) begin
      frame_tog_q <= ~frame_tog_q;
    end
  end

  // ==========================================================
  // Crossing: chip select level through two flops; frame end is its rising edge.
  // Count and shift word are stable once chip select is high, so they are
  // sampled in the system domain only on the synchronised edge.
  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
    end else begin
      cs_s1_q <= i_link_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
    end
  end
  logic        frame_end;   // One-cycle pulse after chip select rises.
  logic [7:0]  opcode;      // Opcode of a one-byte frame or first byte of four.
  logic        one_byte;    // Exactly eight bits were sent.
  logic        four_byte;   // Exactly thirty-two bits were sent.
  logic [23:0] addr;        // Address of a four-byte frame.
  logic        cs_rise;     // Synchronised rising edge of chip select.
  logic        seen_tog_q;  // Frame toggle value taken at the last frame end.
  assign cs_rise = cs_s2_q & ~cs_s3_q;
  // The toggle is stable long before the edge, so it is read only at cs_rise.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seen_tog_q <= 1'b0;
    end else if (cs_rise) begin
      seen_tog_q <= frame_tog_q;
    end
  end
  assign frame_end = cs_rise & (frame_tog_q ^ seen_tog_q);
  assign one_byte  = (bit_cnt_q == 6'h08);
  assign four_byte = (bit_cnt_q == 6'h20);
  assign opcode    = one_byte ? shift_q[7:0] : shift_q[31:24];
  assign addr      = shift_q[23:0];

  // ==========================================================
  // Erase, pause and sleep state.
  typedef enum {
    ST_IDLE,
    ST_ERASE,
    ST_PAUSING,
    ST_PAUSED,
    ST_RESUMING
  } seq_state_t;
  seq_state_t  state_q;
  flash_seq_pkg::erase_kind_t kind_q;
  logic [31:0] remain_q;     // Erase cycles left.
  logic [31:0] wait_q;       // Pause or resume latency counter.
  logic        wel_q;
  logic        sus_q;
  logic        sleep_q;
  logic        sleep_pend_q;
  logic [31:0] sleep_cnt_q;
  logic        go_q;
  logic        done_q;
  logic [23:0] eaddr_q;
  logic        write_in_progress;
  assign write_in_progress = (state_q == ST_ERASE) || (state_q == ST_PAUSING)
               || (state_q == ST_RESUMING);

  // Decoded frames, all blocked while asleep except wake.
  logic cmd_half;
  logic cmd_whole;
  logic cmd_chip;
  logic cmd_pause;
  logic cmd_resume;
  logic cmd_sleep;
  logic cmd_wake;
  logic erase_ok;
  always_comb begin
    logic awake;
    awake      = frame_end & ~sleep_q & ~sleep_pend_q;
    erase_ok   = wel_q & ~sus_q & (state_q == ST_IDLE);
    cmd_half   = awake & four_byte & (opcode == flash_seq_pkg::OP_HALF_BLOCK_ERASE)
                 & erase_ok & ~i_prot_half;
    cmd_whole  = awake & four_byte & (opcode == flash_seq_pkg::OP_WHOLE_BLOCK_ERASE)
                 & erase_ok & ~i_prot_whole;
    cmd_chip   = awake & one_byte & ((opcode == flash_seq_pkg::OP_CHIP_ERASE_A)
                 | (opcode == flash_seq_pkg::OP_CHIP_ERASE_B))
                 & erase_ok & ~i_prot_any;
    cmd_pause  = awake & one_byte & (opcode == flash_seq_pkg::OP_PAUSE) & ~sus_q
                 & (state_q == ST_ERASE) & (kind_q != flash_seq_pkg::ER_CHIP);
    cmd_resume = awake & one_byte & (opcode == flash_seq_pkg::OP_CONTINUE) & sus_q
                 & ~write_in_progress;
    cmd_sleep  = awake & one_byte & (opcode == flash_seq_pkg::OP_SLEEP) & ~write_in_progress;
    cmd_wake   = frame_end & one_byte & (opcode == flash_seq_pkg::OP_WAKE) & ~write_in_progress;
  end

  // Sequencer: erase timing, pause and resume.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q  <= ST_IDLE;
      kind_q   <= flash_seq_pkg::ER_NONE;
      remain_q <= 32'h0;
      wait_q   <= 32'h0;
      sus_q    <= 1'b0;
      go_q     <= 1'b0;
      done_q   <= 1'b0;
      eaddr_q  <= 24'h0;
    end else begin
      go_q   <= 1'b0;
      done_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (cmd_half) begin
            state_q  <= ST_ERASE;
            kind_q   <= flash_seq_pkg::ER_HALF;
            remain_q <= HALF_ERASE_CYC;
            eaddr_q  <= {addr[23:flash_seq_pkg::HALF_BLK_LSB], 15'h0000};
            go_q     <= 1'b1;
          end else if (cmd_whole) begin
            state_q  <= ST_ERASE;
            kind_q   <= flash_seq_pkg::ER_WHOLE;
            remain_q <= WHOLE_ERASE_CYC;
            eaddr_q  <= {addr[23:flash_seq_pkg::WHOLE_BLK_LSB], 16'h0000};
            go_q     <= 1'b1;
          end else if (cmd_chip) begin
            state_q  <= ST_ERASE;
            kind_q   <= flash_seq_pkg::ER_CHIP;
            remain_q <= CHIP_ERASE_CYC;
            eaddr_q  <= 24'h000000;
            go_q     <= 1'b1;
          end else if (cmd_resume) begin
            sus_q   <= 1'b0;
            state_q <= ST_RESUMING;
            wait_q  <= flash_seq_pkg::RESUME_CYC;
          end
        end
        ST_ERASE: begin
          if (cmd_pause) begin
            sus_q   <= 1'b1;
            state_q <= ST_PAUSING;
            wait_q  <= PAUSE_CYC;
          end else if (remain_q <= 32'h1) begin
            state_q <= ST_IDLE;
            kind_q  <= flash_seq_pkg::ER_NONE;
            done_q  <= 1'b1;
          end else begin
            remain_q <= remain_q - 32'h1;
          end
        end
        ST_PAUSING: begin
          if (wait_q <= 32'h1) begin
            state_q <= ST_IDLE;
          end else begin
            wait_q <= wait_q - 32'h1;
          end
        end
        ST_RESUMING: begin
          if (wait_q <= 32'h1) begin
            state_q <= ST_ERASE;
          end else begin
            wait_q <= wait_q - 32'h1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Write enable latch: set by request, cleared when an erase completes.
  // A request in the cycle of completion wins, so the host's set is not lost.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wel_q <= 1'b0;
    end else if (i_wren_pulse && !sleep_q && !write_in_progress && !sus_q) begin
      wel_q <= 1'b1;
    end else if (done_q) begin
      wel_q <= 1'b0;
    end
  end

  // Sleep: entry after latency, release by wake; reset always wakes.
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sleep_q      <= 1'b0;
      sleep_pend_q <= 1'b0;
      sleep_cnt_q  <= 32'h0;
    end else if (cmd_sleep) begin
      sleep_pend_q <= 1'b1;
      sleep_cnt_q  <= SLEEP_CYC;
    end else if (sleep_pend_q) begin
      if (sleep_cnt_q <= 32'h1) begin
        sleep_pend_q <= 1'b0;
        sleep_q      <= 1'b1;
      end else begin
        sleep_cnt_q <= sleep_cnt_q - 32'h1;
      end
    end else if (cmd_wake && sleep_q) begin
      sleep_q <= 1'b0;
    end
  end

  // ==========================================================
  // Status answer: bits held in flops, driven while selected and awake.
  logic [3:0] dq_q;
  logic       dq_oe_q;
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      dq_q    <= 4'h0;
      dq_oe_q <= 1'b0;
    end else begin
      dq_q    <= {sus_q, 1'b0, wel_q, write_in_progress};
      dq_oe_q <= ~cs_s2_q & ~sleep_q;
    end
  end
  assign o_link_dq            = dq_q;
  assign o_link_dq_oe         = {4{dq_oe_q}};
  assign o_write_in_progress  = write_in_progress;
  assign o_write_enable_latch = wel_q;
  assign o_erase_paused_flag  = sus_q;
  assign o_asleep             = sleep_q;
  assign o_erase_go           = go_q;
  assign o_erase_kind         = kind_q;
  assign o_erase_addr         = eaddr_q;
  assign o_erase_done         = done_q;
endmodule

/* File: hw/flash_seq_pkg.sv */
// Shared opcodes, status bit positions and timing counts of the erase sequencer.
package flash_seq_pkg;
  // ==========================================================
  // Opcodes
  localparam logic [7:0] OP_HALF_BLOCK_ERASE  = 8'h52;
  localparam logic [7:0] OP_WHOLE_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A      = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B      = 8'h60;
  localparam logic [7:0] OP_PAUSE             = 8'h75;
  localparam logic [7:0] OP_CONTINUE          = 8'h7a;
  localparam logic [7:0] OP_SLEEP             = 8'hb9;
  localparam logic [7:0] OP_WAKE              = 8'hab;
  localparam logic [7:0] OP_WRITE_ENABLE      = 8'h06;
  localparam logic [7:0] OP_READ_STATUS       = 8'h05;
  // ==========================================================
  // Status register bit positions.
  localparam int unsigned ST_WIP_BIT = 0;
  localparam int unsigned ST_WEL_BIT = 1;
  localparam int unsigned ST_SUS_BIT = 7;
  // ==========================================================
  // Geometry: address bits that select a block.
  localparam int unsigned ADDR_W        = 24;
  localparam int unsigned HALF_BLK_LSB  = 15;
  localparam int unsigned WHOLE_BLK_LSB = 16;
  // ==========================================================
  // Timing, in nanoseconds, and the system clock period.
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned RESUME_NS        = 200;
  localparam int unsigned PAUSE_LAT_NS     = 20000;
  localparam int unsigned SLEEP_ENTRY_NS   = 3000;
  localparam int unsigned WAKE_NS          = 3000;
  // Times round down; only RESUME_CYC is held to at least one cycle.
  localparam int unsigned RESUME_CYC      = (RESUME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            RESUME_NS / CLK_PERIOD_NS;
  localparam int unsigned PAUSE_LAT_CYC   = PAUSE_LAT_NS / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC        = WAKE_NS / CLK_PERIOD_NS;
  // Default erase durations in cycles (kept long; top parameters shorten them).
  localparam int unsigned HALF_BLOCK_ERASE_CYC  = 3000000;
  localparam int unsigned WHOLE_BLOCK_ERASE_CYC = 5000000;
  localparam int unsigned FULL_ARRAY_ERASE_CYC  = 100000000;
  // ==========================================================
  // Kind of erase that is running or paused.
  typedef enum logic [1:0] {
    ER_NONE,
    ER_HALF,
    ER_WHOLE,
    ER_CHIP
  } erase_kind_t;
endpackage
